// ==== design/sfp_pkg.sv ====
// Purpose: shared constants for the serial flash status and protection front-end
// Assumes: 40 MHz system clock, eight-bit opcodes sent most significant bit first
// Notes: identity bytes are arbitrary neutral values

package sfp_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_IDENTITY = 8'h9f;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_READ = 8'h03;

    // ----------------------------------------------------------------
    // status layout and reset
    // ----------------------------------------------------------------
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_LEVEL_LO_BIT = 2;
    localparam int ST_LEVEL_HI_BIT = 4;
    localparam int ST_ZERO_BIT = 5;
    localparam int ST_FAIL_BIT = 6;
    localparam int ST_LOCK_BIT = 7;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam logic LOCK_RESET = 1'b0;

    // identity bytes, values arbitrary
    localparam logic [7:0] ID_MAKER = 8'h5a;
    localparam logic [7:0] ID_TYPE = 8'h3c;
    localparam logic [7:0] ID_PART = 8'h11;

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BYTE_MAX = 3'h7;
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_TWO = 3'h2;
    localparam logic [2:0] BYTES_ADDR_END = 3'h3;
    localparam logic [2:0] ID_SECOND = 3'h1;
    localparam logic [2:0] ID_THIRD = 3'h2;
    localparam int ADDR_W = 24;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int STATUS_WRITE_TIME_NS = 10000;
    localparam int TW_W = 9;
    localparam logic [TW_W-1:0] TW_COUNT =
        TW_W'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW_W-1:0] TW_LAST = 9'h001;

    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_ID = 3'b011,
        ST_STAT = 3'b100,
        ST_WDATA = 3'b101,
        ST_HOLD = 3'b110,
        ST_IDLE = 3'b111
    } sfp_state_t;

endpackage

// ==== design/sfp_sync.sv ====
// Purpose: two-flop level synchroniser
// Assumes: each bit is an independent level
// Notes: reset is synchronous to the destination clock

`timescale 1ns/1ps
`default_nettype none

module sfp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ==== design/sfp_flash_front.sv ====
// Purpose: serial flash command front-end: latch, identity, status, protection, array read
// Assumes: sck_in toggles while chip select is high only for a polarity change between frames; memory answers mem_data_in combinationally
// Notes: program and erase engine lives outside and reports through op_busy_in and op_fail_in

`timescale 1ns/1ps
`default_nettype none

module sfp_flash_front (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic chip_sel_n_in,
    input wire logic serial_in,
    input wire logic wp_n_in,
    input wire logic [7:0] mem_data_in,
    input wire logic op_busy_in,
    input wire logic op_fail_in,
    output logic serial_out,
    output logic serial_oe_n_out,
    output logic [sfp_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [7:0] status_out,
    output logic [2:0] protect_level_out,
    output logic hard_protect_out,
    output logic chip_erase_ok_out
);
    import sfp_pkg::*;

    // ----------------------------------------------------------------
    // link side, rising edge
    // ----------------------------------------------------------------
    logic first_reg;
    logic [2:0] cnt_reg;
    logic [2:0] byte_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [7:0] wdata_reg;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic tgl_reg;
    sfp_state_t state_reg;
    sfp_state_t state_next;
    logic [7:0] status_sck;
    logic [7:0] out_sr_reg;
    logic [7:0] next_byte;
    logic [2:0] cnt_now;
    logic [2:0] byte_now;
    sfp_state_t state_now;
    logic [7:0] shift_v;
    logic byte_done;
    logic busy_sck;
    logic drive;

    // marks the first edge of a frame; chip select high arms it
    always_ff @(posedge sck_in or posedge chip_sel_n_in) begin
        if (chip_sel_n_in) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // counters are restarted by the first edge instead of cleared by chip select,
    // so the frame's result stays put for the system side after the frame ends
    assign cnt_now = first_reg ? 3'h0 : cnt_reg;
    assign byte_now = first_reg ? 3'h0 : byte_reg;
    assign state_now = first_reg ? ST_OPC : state_reg;
    assign shift_v = {shift_reg[6:0], serial_in};
    assign byte_done = (cnt_now == BIT_LAST);
    assign busy_sck = status_sck[ST_BUSY_BIT];

    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= 3'h0;
            byte_reg <= 3'h0;
            shift_reg <= 8'h00;
            tgl_reg <= 1'b0;
        end else if (!chip_sel_n_in) begin
            // edges while deselected (a polarity change between frames) must not fake a frame
            cnt_reg <= cnt_now + 3'h1;
            shift_reg <= shift_v;
            byte_reg <= (byte_done && byte_now != BYTE_MAX) ? byte_now + 3'h1 : byte_now;
            if (first_reg) begin
                tgl_reg <= ~tgl_reg;
            end
        end
    end

    always_comb begin
        state_next = state_now;
        tx_next = tx_reg;
        case (state_now)
            ST_OPC: begin
                if (byte_done) begin
                    case (shift_v)
                        OPC_WRITE_ENABLE, OPC_WRITE_DISABLE: begin
                            state_next = ST_HOLD;
                        end
                        OPC_STATUS_WRITE: begin
                            state_next = ST_WDATA;
                        end
                        OPC_STATUS_READ: begin
                            state_next = ST_STAT;
                            tx_next = status_sck;
                        end
                        OPC_READ_IDENTITY: begin
                            state_next = busy_sck ? ST_IDLE : ST_ID;
                            tx_next = ID_MAKER;
                        end
                        OPC_ARRAY_READ: begin
                            state_next = busy_sck ? ST_IDLE : ST_ADDR;
                        end
                        default: begin
                            state_next = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_ADDR: begin
                if (byte_done && byte_now == BYTES_ADDR_END) begin
                    state_next = ST_DATA;
                end
            end
            ST_ID: begin
                if (byte_done) begin
                    if (byte_now == ID_SECOND) begin
                        tx_next = ID_TYPE;
                    end else if (byte_now == ID_THIRD) begin
                        tx_next = ID_PART;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_STAT: begin
                if (byte_done) begin
                    tx_next = status_sck;
                end
            end
            ST_WDATA: begin
                if (byte_done) begin
                    state_next = ST_HOLD;
                end
            end
            default: begin
                state_next = state_now;
            end
        endcase
    end

    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            tx_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            tx_reg <= tx_next;
        end
    end

    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            opcode_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end else begin
            if (state_now == ST_OPC && byte_done) begin
                opcode_reg <= shift_v;
            end
            if (state_now == ST_WDATA && byte_done) begin
                wdata_reg <= shift_v;
            end
        end
    end

    // address shifts in, then advances after each byte; 24-bit wrap is natural
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            mem_addr_out <= '0;
        end else if (byte_done && state_now == ST_ADDR) begin
            mem_addr_out <= {mem_addr_out[15:0], shift_v};
        end else if (byte_done && state_now == ST_DATA) begin
            mem_addr_out <= mem_addr_out + ADDR_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // link side, falling edge output
    // ----------------------------------------------------------------
    // in mode 3 a falling edge precedes the first rising one; first_reg keeps it quiet
    assign drive = !first_reg && (state_reg == ST_ID || state_reg == ST_STAT || state_reg == ST_DATA);
    assign next_byte = (state_reg == ST_DATA) ? mem_data_in : tx_reg;

    always_ff @(negedge sck_in or posedge chip_sel_n_in) begin
        if (chip_sel_n_in) begin
            serial_oe_n_out <= 1'b1;
            serial_out <= 1'b0;
            out_sr_reg <= 8'h00;
        end else begin
            serial_oe_n_out <= !drive;
            if (cnt_reg == 3'h0) begin
                serial_out <= next_byte[7];
                out_sr_reg <= {next_byte[6:0], 1'b0};
            end else begin
                serial_out <= out_sr_reg[7];
                out_sr_reg <= {out_sr_reg[6:0], 1'b0};
            end
        end
    end

    sfp_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_status_sync (
        .clk_in(sck_in),
        .rst_in(1'b0),
        .d_in(status_out),
        .q_out(status_sck)
    );

    // ----------------------------------------------------------------
    // system side
    // ----------------------------------------------------------------
    logic csn_s;
    logic wp_s;
    logic tgl_s;
    logic csn_d_reg;
    logic tgl_seen_reg;
    logic wel_reg;
    logic lock_reg;
    logic [2:0] level_reg;
    logic [TW_W-1:0] tw_cnt_reg;
    logic [7:0] pend_reg;
    logic busy_d_reg;
    logic frame_end;
    logic frame_new;
    logic aligned;
    logic tw_run;
    logic tw_done;
    logic busy;
    logic hard_protect_mode;
    logic prog_done;
    logic write_enable_cmd_ok;
    logic write_disable_cmd_ok;
    logic status_write_cmd_ok;

    sfp_sync #(.WIDTH(3), .RST_VAL(3'b110)) u_pin_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({chip_sel_n_in, wp_n_in, tgl_reg}),
        .q_out({csn_s, wp_s, tgl_s})
    );

    // frame words are static once chip select is high; the toggle says a frame happened
    assign frame_end = csn_s && !csn_d_reg;
    assign frame_new = frame_end && (tgl_s != tgl_seen_reg);
    assign aligned = (cnt_reg == 3'h0);
    assign tw_run = (tw_cnt_reg != '0);
    assign tw_done = (tw_cnt_reg == TW_LAST);
    assign busy = tw_run || op_busy_in;
    assign hard_protect_mode = lock_reg && !wp_s;
    assign prog_done = busy_d_reg && !op_busy_in;
    assign write_enable_cmd_ok = frame_new && aligned && byte_reg == BYTES_ONE && opcode_reg == OPC_WRITE_ENABLE;
    assign write_disable_cmd_ok = frame_new && aligned && byte_reg == BYTES_ONE && opcode_reg == OPC_WRITE_DISABLE;
    assign status_write_cmd_ok = frame_new && aligned && byte_reg == BYTES_TWO && opcode_reg == OPC_STATUS_WRITE
                     && wel_reg && !busy && !hard_protect_mode;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            csn_d_reg <= 1'b1;
            tgl_seen_reg <= 1'b0;
            busy_d_reg <= 1'b0;
        end else begin
            csn_d_reg <= csn_s;
            busy_d_reg <= op_busy_in;
            if (frame_end) begin
                tgl_seen_reg <= tgl_s;
            end
        end
    end

    // set wins over every clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wel_reg <= 1'b0;
        end else if (write_enable_cmd_ok) begin
            wel_reg <= 1'b1;
        end else if (write_disable_cmd_ok || tw_done || prog_done) begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tw_cnt_reg <= '0;
            pend_reg <= 8'h00;
        end else if (status_write_cmd_ok) begin
            tw_cnt_reg <= TW_COUNT;
            pend_reg <= wdata_reg;
        end else if (tw_run) begin
            tw_cnt_reg <= tw_cnt_reg - TW_LAST;
        end
    end

    // cannot model nonvolatility; reset gives a defined start instead
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lock_reg <= LOCK_RESET;
            level_reg <= LEVEL_RESET;
        end else if (tw_done) begin
            lock_reg <= pend_reg[ST_LOCK_BIT];
            level_reg <= pend_reg[ST_LEVEL_HI_BIT:ST_LEVEL_LO_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out <= 8'h00;
            protect_level_out <= LEVEL_RESET;
            hard_protect_out <= 1'b0;
            chip_erase_ok_out <= 1'b0;
        end else begin
            status_out <= {lock_reg, op_fail_in, 1'b0, level_reg, wel_reg, busy};
            protect_level_out <= level_reg;
            hard_protect_out <= hard_protect_mode;
            chip_erase_ok_out <= wel_reg && !busy && level_reg == 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_tw_busy;
        status_out[ST_BUSY_BIT] [*8];
    endsequence

    sequence s_tw_finish;
        !tw_run && !wel_reg ##1 !status_out[ST_WEL_BIT];
    endsequence

    property p_wel_set;
        write_enable_cmd_ok |=> wel_reg ##1 status_out[ST_WEL_BIT];
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");

    property p_wel_clear;
        write_disable_cmd_ok && !write_enable_cmd_ok |=> !wel_reg;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");

    property p_prog_done;
        prog_done && !write_enable_cmd_ok |=> !wel_reg;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("latch kept after program");

    property p_status_write_cmd_busy;
        status_write_cmd_ok |=> ##1 s_tw_busy;
    endproperty
    a_status_write_cmd_busy: assert property (p_status_write_cmd_busy) else $error("busy not shown");

    property p_tw_end;
        tw_done && !write_enable_cmd_ok && !op_busy_in |=> s_tw_finish;
    endproperty
    a_tw_end: assert property (p_tw_end) else $error("write cycle end wrong");

    property p_hpm_reject;
        frame_end && hard_protect_mode && !tw_run |=> !tw_run;
    endproperty
    a_hpm_reject: assert property (p_hpm_reject) else $error("write under lock");

    property p_wel_gate;
        frame_end && !wel_reg && !tw_run |=> !tw_run;
    endproperty
    a_wel_gate: assert property (p_wel_gate) else $error("write without latch");

    property p_misaligned;
        frame_new && !aligned && !tw_run |=> !tw_run;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("unaligned write ran");

    property p_apply;
        tw_done |=> lock_reg == $past(pend_reg[ST_LOCK_BIT])
            && level_reg == $past(pend_reg[ST_LEVEL_HI_BIT:ST_LEVEL_LO_BIT]);
    endproperty
    a_apply: assert property (p_apply) else $error("status bits not applied");

    property p_zero_bit;
        !status_out[ST_ZERO_BIT] && (status_out[ST_FAIL_BIT] == $past(op_fail_in));
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("bit 5 or fail bit wrong");

    property p_release;
        csn_s |-> serial_oe_n_out;
    endproperty
    a_release: assert property (p_release) else $error("output driven outside frame");

    property p_hard_out;
        lock_reg && !wp_s |=> hard_protect_out;
    endproperty
    a_hard_out: assert property (p_hard_out) else $error("hard protection not shown");

endmodule

`default_nettype wire

// ==== test/sfp_spi_master.sv ====
// Purpose: spi bus master model driving the flash front-end link
// Assumes: 160 ns link clock that runs only inside frames
// Notes: cpol picks mode 0 or mode 3

`timescale 1ns/1ps
`default_nettype none

module sfp_spi_master (
    output logic sck_out,
    output logic csn_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic oe_n_in
);
    logic cpol = 1'b0;
    logic drv = 1'b0;

    // chip select rises just after time zero so its edge resets the link side
    initial begin
        sck_out = 1'b0;
        csn_out = 1'b0;
        si_out = 1'b0;
        #1 csn_out = 1'b1;
    end

    // --------------------------------
    // frame tasks
    // --------------------------------
    task automatic fbegin();
        sck_out = cpol;
        drv = 1'b0;
        #40 csn_out = 1'b0;
        #80;
    endtask

    // msb first, data set while clock low, sampled at the rising edge
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            sck_out = 1'b0;
            si_out = tx[i];
            #80 sck_out = 1'b1;
            // a released output reads as the inverse of its stale value
            rx[i] = (oe_n_in === 1'b0) ? so_in : ~so_in;
            if (oe_n_in === 1'b0) drv = 1'b1;
            #80;
        end
    endtask

    // released input shows the inverse, the gap covers frame-end sync
    task automatic fend();
        sck_out = cpol;
        #80 csn_out = 1'b1;
        si_out = ~si_out;
        #300;
    endtask
endmodule

`default_nettype wire

// ==== test/sfp_flash_front_tb_top.sv ====
// Purpose: self-checking bench for the flash command front-end
// Assumes: memory byte is a fixed pattern of its address
// Notes: integer model of status compared by chk_st after selected frames, not after every frame

`timescale 1ns/1ps
`default_nettype none

module sfp_flash_front_tb_top;
    import sfp_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b0;
    logic wp_n = 1'b1;
    logic op_busy = 1'b0;
    logic op_fail = 1'b0;
    logic sck, csn, si, so, oe_n, hard, ce_ok;
    logic [7:0] mem_data, st_port;
    logic [23:0] mem_addr;
    logic [2:0] lvl_port;
    logic [7:0] rxq[$];
    logic [7:0] id_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int m_wel = 0, m_busy = 0, m_lock = 0, m_fail = 0, m_lvl = 0;

    always #12.5 clk_in = ~clk_in;
    assign mem_data = mem_addr[7:0] ^ mem_addr[23:16] ^ 8'h3a;

    sfp_flash_front i_sfp_flash_front (
        .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .chip_sel_n_in(csn),
        .serial_in(si), .wp_n_in(wp_n), .mem_data_in(mem_data),
        .op_busy_in(op_busy), .op_fail_in(op_fail), .serial_out(so),
        .serial_oe_n_out(oe_n), .mem_addr_out(mem_addr), .status_out(st_port),
        .protect_level_out(lvl_port), .hard_protect_out(hard), .chip_erase_ok_out(ce_ok)
    );

    sfp_spi_master i_sfp_spi_master (
        .sck_out(sck), .csn_out(csn), .si_out(si), .so_in(so), .oe_n_in(oe_n)
    );

    // --------------------------------
    // checking and model
    // --------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    function automatic logic [7:0] mst();
        return {m_lock[0], m_fail[0], 1'b0, m_lvl[2:0], m_wel[0], m_busy[0]};
    endfunction

    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h3a;
    endfunction

    // whole frame, last byte may be cut short
    task automatic frame(input logic [7:0] txq[$], input int nb_last);
        logic [7:0] r;
        rxq = {};
        i_sfp_spi_master.fbegin();
        foreach (txq[i]) begin
            i_sfp_spi_master.xfer(txq[i], (i == txq.size() - 1) ? nb_last : 8, r);
            rxq.push_back(r);
        end
        i_sfp_spi_master.fend();
    endtask

    task automatic chk_st();
        frame('{OPC_STATUS_READ, 8'h00, 8'h00}, 8);
        chk("status_spi", mst(), rxq[1]);
        chk("status_rpt", mst(), rxq[2]);
        chk("status_port", mst(), st_port);
        chk("oe_idle", 8'h01, {7'h0, oe_n});
        chk("levels", 8'(m_lvl), {5'h0, lvl_port});
    endtask

    task automatic wr(input logic [7:0] d, input int nb);
        logic ok;
        ok = m_wel == 1 && m_busy == 0 && !(m_lock == 1 && wp_n == 1'b0) && nb == 8;
        frame('{OPC_STATUS_WRITE, d}, nb);
        if (ok) begin
            m_busy = 1;
            chk_st();
            for (int t = 0; t < 1000 && st_port[0] !== 1'b0; t++) begin
                @(posedge clk_in);
                #2;
            end
            chk("busy_end", 8'h00, {7'h0, st_port[0]});
            if (st_port[0] !== 1'b0) close_out();
            m_busy = 0;
            m_wel = 0;
            m_lock = d[7];
            m_lvl = d[4:2];
        end
        chk_st();
    endtask

    task automatic pins(input logic w, input logic b, input logic f);
        @(posedge clk_in);
        #2 wp_n = w;
        op_busy = b;
        op_fail = f;
        repeat (6) @(posedge clk_in);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        logic [7:0] d;
        // raised after time zero so the link-side asynchronous reset sees an edge
        #1 rst_in = 1'b1;
        void'($urandom(26));
        repeat (10) @(posedge clk_in);
        #2 rst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        chk_st();
        for (int p = 0; p < 2; p++) begin
            i_sfp_spi_master.cpol = p[0];
            frame('{OPC_WRITE_ENABLE}, 8);
            m_wel = 1;
            chk_st();
            frame('{OPC_WRITE_DISABLE}, 8);
            m_wel = 0;
            chk_st();
        end
        d = 8'($urandom()) | 8'h80;
        wr(d, 8);
        frame('{OPC_WRITE_ENABLE}, 8);
        m_wel = 1;
        wr(d, 7);
        wr(d, 8);
        pins(1'b0, 1'b0, 1'b0);
        chk("hard_on", 8'h01, {7'h0, hard});
        frame('{OPC_WRITE_ENABLE}, 8);
        m_wel = 1;
        chk("erase_gate", 8'(m_lvl == 0), {7'h0, ce_ok});
        wr(8'h00, 8);
        pins(1'b1, 1'b0, 1'b0);
        chk("hard_off", 8'h00, {7'h0, hard});
        wr(8'h00, 8);
        frame('{OPC_WRITE_ENABLE}, 8);
        m_wel = 1;
        chk("erase_ok", 8'h01, {7'h0, ce_ok});
        id_q = '{ID_MAKER, ID_TYPE, ID_PART};
        frame('{OPC_READ_IDENTITY, 8'h00, 8'h00, 8'h00}, 8);
        for (int i = 1; i < 4; i++) chk("identity", id_q.pop_front(), rxq[i]);
        pins(1'b1, 1'b1, 1'b1);
        m_busy = 1;
        m_fail = 1;
        frame('{OPC_READ_IDENTITY, 8'h00}, 8);
        chk("id_busy", 8'h00, {7'h0, i_sfp_spi_master.drv});
        chk_st();
        pins(1'b1, 1'b0, 1'b1);
        m_busy = 0;
        m_wel = 0;
        chk_st();
        frame('{OPC_ARRAY_READ, 8'hff, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00}, 8);
        chk("rd0", pat(24'hfffffe), rxq[4]);
        chk("rd1", pat(24'hffffff), rxq[5]);
        chk("rd2", pat(24'h000000), rxq[6]);
        frame('{8'hff, 8'h00}, 8);
        chk("unknown", 8'h00, {7'h0, i_sfp_spi_master.drv});
        chk_st();
        close_out();
    end
endmodule

`default_nettype wire
